/* shared/rdsc_pkg.sv */
package rdsc_pkg;
  // register offsets
  localparam logic [7:0] OFS_OVR  = 8'h02;
  localparam logic [7:0] OFS_RSV3 = 8'h03;
  localparam logic [7:0] OFS_RSV4 = 8'h04;
  localparam logic [7:0] OFS_RSV5 = 8'h05;
  localparam logic [7:0] OFS_SLV  = 8'h06;
  localparam logic [7:0] OFS_DRST = 8'h07;
  // field positions
  localparam int BIT_DET_OVR  = 7;
  localparam int BIT_DET_VAL  = 6;
  localparam int BIT_PD_OVR   = 0;
  localparam int BIT_REG_EN   = 3;
  localparam int BIT_RST_REGS = 6;
  localparam int BIT_RST_MST  = 5;
  // reset values; fixed bits read back as their defaults
  localparam logic [7:0] RST_OVR  = 8'h00;
  localparam logic [7:0] RST_SLV  = 8'h10;
  localparam logic [7:0] RST_DRST = 8'h01;
  localparam logic [7:0] RST_RSV  = 8'h00;
  // slave address, arbitrary value; strapping is outside this block
  localparam logic [6:0] DEV_ADDR = 7'h58;
  localparam int CHANS = 8;
  localparam int SET_W = 3;
  localparam logic [3:0] BITS_BYTE = 4'h8;
  localparam logic [3:0] LAST_BIT  = 4'h7;
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_DEV  = 6'h02,
    S_ACK  = 6'h04,
    S_RCV  = 6'h08,
    S_SEND = 6'h10,
    S_MACK = 6'h20
  } rdsc_state_e;
endpackage : rdsc_pkg

/* rtl/rdsc_smb_slave.sv */
`timescale 1ns/10ps
`default_nettype none
module rdsc_smb_slave (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       scl,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOen_n,
  input  wire logic [7:0] rdData,
  output logic      [7:0] regAddr,
  output logic      [7:0] wrData,
  output logic            wrStb
);
  rdsc_pkg::rdsc_state_e stateR;
  logic       sclQ;
  logic       sdaQ;
  logic [7:0] shR;
  logic [3:0] cntR;
  logic       rwR;
  logic       byteR;
  logic [7:0] regAddrR;
  logic [7:0] wrDataR;
  logic       wrStbR;

  wire sclRise  = scl & ~sclQ;
  wire sclFall  = ~scl & sclQ;
  wire startC   = scl & sclQ & sdaQ & ~sdaIn;
  wire stopC    = scl & sclQ & ~sdaQ & sdaIn;
  wire byteDone = sclFall && (cntR == rdsc_pkg::BITS_BYTE);
  wire addrHit  = shR[7:1] == rdsc_pkg::DEV_ADDR;
  wire [7:0] shIn = {shR[6:0], sdaIn};
  wire [3:0] cntInc = 4'(cntR + 4'h1);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sclQ <= 1'b1;
      sdaQ <= 1'b1;
    end else begin
      sclQ <= scl;
      sdaQ <= sdaIn;
    end
  end

  always_ff @(posedge clock) begin
    wrStbR <= 1'b0;
    if (!rst_n) begin
      stateR   <= rdsc_pkg::S_IDLE;
      shR      <= 8'h00;
      cntR     <= 4'h0;
      rwR      <= 1'b0;
      byteR    <= 1'b0;
      regAddrR <= 8'h00;
      wrDataR  <= 8'h00;
    end else if (startC) begin
      stateR <= rdsc_pkg::S_DEV;
      cntR   <= 4'h0;
      byteR  <= 1'b0;
    end else if (stopC) begin
      stateR <= rdsc_pkg::S_IDLE;
    end else begin
      case (stateR)
        rdsc_pkg::S_DEV: begin
          if (sclRise) begin
            shR  <= shIn;
            cntR <= cntInc;
          end else if (byteDone) begin
            rwR    <= shR[0];
            stateR <= addrHit ? rdsc_pkg::S_ACK : rdsc_pkg::S_IDLE;
          end
        end
        rdsc_pkg::S_RCV: begin
          if (sclRise) begin
            shR  <= shIn;
            cntR <= cntInc;
          end else if (byteDone) begin
            stateR <= rdsc_pkg::S_ACK;
            byteR  <= 1'b1;
            if (!byteR) begin
              regAddrR <= shR;
            end else begin
              wrDataR <= shR;
              wrStbR  <= 1'b1;
            end
          end
        end
        rdsc_pkg::S_ACK: begin
          if (sclFall) begin
            cntR <= 4'h0;
            if (rwR) begin
              stateR <= rdsc_pkg::S_SEND;
              shR    <= rdData;
            end else begin
              stateR <= rdsc_pkg::S_RCV;
            end
          end
        end
        rdsc_pkg::S_SEND: begin
          if (sclFall) begin
            shR  <= {shR[6:0], 1'b0};
            cntR <= cntInc;
            if (cntR == rdsc_pkg::LAST_BIT) begin
              stateR <= rdsc_pkg::S_MACK;
            end
          end
        end
        rdsc_pkg::S_MACK: begin
          // host nack ends the read; ack repeats the register
          if (sclRise && sdaIn) begin
            stateR <= rdsc_pkg::S_IDLE;
          end else if (sclRise) begin
            cntR <= 4'h0;
          end else if (sclFall && cntR == 4'h0) begin
            stateR <= rdsc_pkg::S_SEND;
            shR    <= rdData;
          end
        end
        default: begin
          stateR <= rdsc_pkg::S_IDLE;
        end
      endcase
    end
  end

  wire driveLow = (stateR == rdsc_pkg::S_ACK) ||
                  (stateR == rdsc_pkg::S_SEND && !shR[7]);
  assign sdaOut   = 1'b0;
  assign sdaOen_n = ~driveLow;
  assign regAddr  = regAddrR;
  assign wrData   = wrDataR;
  assign wrStb    = wrStbR;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_ack_data: assert property (
    (stateR == rdsc_pkg::S_RCV) && byteDone && !startC && !stopC
    |=> !sdaOen_n && stateR == rdsc_pkg::S_ACK)
    else $error("no ack after received byte");
  a_ack_addr: assert property (
    (stateR == rdsc_pkg::S_DEV) && byteDone && !addrHit && !startC
    && !stopC |=> sdaOen_n)
    else $error("acked a foreign address");
endmodule : rdsc_smb_slave
`default_nettype wire

/* rtl/rdsc_ctrl_regs.sv */
// How it works
// - override register bit 6 sets or clears the rx-detect machine reset.
// - override bit 0 set: register power-down; clear: power-down pin rules.
// - slave control bit 3 enables register control; register resets to 0x10.
// - register swing, de-emphasis, boost reach channels only while enabled.
// - reset register bit 6 returns all registers to defaults, self-clears.
// - reset register bit 5 resets the eeprom-loading master, self-clears.
// - override bit 7 lets register value replace automatic rx-detect reset.
// - write is start, address, offset, one data byte, acks, stop.
`timescale 1ns/10ps
`default_nettype none
module rdsc_ctrl_regs (
  input  wire logic                       clock,
  input  wire logic                       rst_n,
  input  wire logic                       scl,
  input  wire logic                       sdaIn,
  output logic                            sdaOut,
  output logic                            sdaOen_n,
  input  wire logic                       powerDownPin,
  input  wire logic [rdsc_pkg::CHANS-1:0] channelPowerDownReg,
  output logic      [rdsc_pkg::CHANS-1:0] channel_power_down,
  input  wire logic                       rxDetectAutoReset,
  output logic                            rxDetectReset,
  input  wire logic [rdsc_pkg::SET_W-1:0] pinSwing,
  input  wire logic [rdsc_pkg::SET_W-1:0] pinDeemphasis,
  input  wire logic [rdsc_pkg::SET_W-1:0] pinBoost,
  input  wire logic [rdsc_pkg::SET_W-1:0] regSwing,
  input  wire logic [rdsc_pkg::SET_W-1:0] regDeemphasis,
  input  wire logic [rdsc_pkg::SET_W-1:0] regBoost,
  output logic      [rdsc_pkg::SET_W-1:0] output_swing,
  output logic      [rdsc_pkg::SET_W-1:0] output_deemphasis,
  output logic      [rdsc_pkg::SET_W-1:0] equalizer_boost,
  output logic                            registerEnable,
  output logic                            registerFileReset,
  output logic                            masterSmReset
);
  logic [7:0] regAddr;
  logic [7:0] wrData;
  logic       wrStb;
  logic [7:0] rdData;

  logic rx_detect_reset_override_r;
  logic rx_detect_reset_value_r;
  logic power_down_pin_override_r;
  logic regEnR;
  logic rstRegsR;
  logic rstMstR;
  logic [rdsc_pkg::SET_W-1:0] swingR;
  logic [rdsc_pkg::SET_W-1:0] deemphR;
  logic [rdsc_pkg::SET_W-1:0] boostR;

  rdsc_smb_slave u_slave (
    .clock    (clock),
    .rst_n    (rst_n),
    .scl      (scl),
    .sdaIn    (sdaIn),
    .sdaOut   (sdaOut),
    .sdaOen_n (sdaOen_n),
    .rdData   (rdData),
    .regAddr  (regAddr),
    .wrData   (wrData),
    .wrStb    (wrStb)
  );

  // write decode
  wire wrOvr  = wrStb && regAddr == rdsc_pkg::OFS_OVR;
  wire wrSlv  = wrStb && regAddr == rdsc_pkg::OFS_SLV;
  wire wrDrst = wrStb && regAddr == rdsc_pkg::OFS_DRST;

  // read-back images; reserved bits return their defaults
  wire [7:0] rdOvr = {rx_detect_reset_override_r,
                      rx_detect_reset_value_r,
                      5'h00, power_down_pin_override_r};
  wire [7:0] rdSlv = rdsc_pkg::RST_SLV |
                     (8'(regEnR) << rdsc_pkg::BIT_REG_EN);
  wire [7:0] rdDrst = rdsc_pkg::RST_DRST |
                      (8'(rstRegsR) << rdsc_pkg::BIT_RST_REGS) |
                      (8'(rstMstR) << rdsc_pkg::BIT_RST_MST);

  assign rdData = (regAddr == rdsc_pkg::OFS_OVR)  ? rdOvr  :
                  (regAddr == rdsc_pkg::OFS_SLV)  ? rdSlv  :
                  (regAddr == rdsc_pkg::OFS_DRST) ? rdDrst :
                  rdsc_pkg::RST_RSV;

  // register file reset
  // a synchronous reset term, so the pulse lasts exactly one cycle
  wire softClear = !rst_n || rstRegsR;

  always_ff @(posedge clock) begin
    if (softClear) begin
      rx_detect_reset_override_r <= rdsc_pkg::RST_OVR[rdsc_pkg::BIT_DET_OVR];
      rx_detect_reset_value_r    <= rdsc_pkg::RST_OVR[rdsc_pkg::BIT_DET_VAL];
      power_down_pin_override_r  <= rdsc_pkg::RST_OVR[rdsc_pkg::BIT_PD_OVR];
    end else if (wrOvr) begin
      rx_detect_reset_override_r <= wrData[rdsc_pkg::BIT_DET_OVR];
      rx_detect_reset_value_r    <= wrData[rdsc_pkg::BIT_DET_VAL];
      power_down_pin_override_r  <= wrData[rdsc_pkg::BIT_PD_OVR];
    end
  end

  always_ff @(posedge clock) begin
    if (softClear) begin
      regEnR <= rdsc_pkg::RST_SLV[rdsc_pkg::BIT_REG_EN];
    end else if (wrSlv) begin
      regEnR <= wrData[rdsc_pkg::BIT_REG_EN];
    end
  end

  // master reset pulse
  // writes are a full byte apart, so a clear never meets a new set
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rstRegsR <= rdsc_pkg::RST_DRST[rdsc_pkg::BIT_RST_REGS];
      rstMstR  <= rdsc_pkg::RST_DRST[rdsc_pkg::BIT_RST_MST];
    end else begin
      rstRegsR <= wrDrst && wrData[rdsc_pkg::BIT_RST_REGS];
      rstMstR  <= wrDrst && wrData[rdsc_pkg::BIT_RST_MST];
    end
  end

  // gate settings
  // hold last applied values while disabled would surprise; pins rule instead
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      swingR  <= '0;
      deemphR <= '0;
      boostR  <= '0;
    end else begin
      swingR  <= regEnR ? regSwing      : pinSwing;
      deemphR <= regEnR ? regDeemphasis : pinDeemphasis;
      boostR  <= regEnR ? regBoost      : pinBoost;
    end
  end

  wire [rdsc_pkg::CHANS-1:0] pdSel = power_down_pin_override_r ?
                  channelPowerDownReg : {rdsc_pkg::CHANS{powerDownPin}};
  wire rxSel = rx_detect_reset_override_r ?
               rx_detect_reset_value_r : rxDetectAutoReset;

  logic [rdsc_pkg::CHANS-1:0] pdR;
  logic                       rxR;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pdR <= '0;
      rxR <= 1'b0;
    end else begin
      pdR <= pdSel;
      rxR <= rxSel;
    end
  end

  assign channel_power_down = pdR;
  assign rxDetectReset      = rxR;
  assign output_swing       = swingR;
  assign output_deemphasis  = deemphR;
  assign equalizer_boost    = boostR;
  assign registerEnable     = regEnR;
  assign registerFileReset  = rstRegsR;
  assign masterSmReset      = rstMstR;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_rst_req;
    wrDrst && wrData[rdsc_pkg::BIT_RST_REGS];
  endsequence
  sequence s_defaults;
    rdOvr == rdsc_pkg::RST_OVR && rdSlv == rdsc_pkg::RST_SLV;
  endsequence
  sequence s_mst_req;
    wrDrst && wrData[rdsc_pkg::BIT_RST_MST];
  endsequence

  a_det_value: assert property (
    wrOvr && wrData[7] && wrStb ##1 !wrOvr [*2] |-> rxDetectReset ==
    $past(wrData[rdsc_pkg::BIT_DET_VAL], 2))
    else $error("rx-detect reset does not follow value bit");
  a_det_auto: assert property (
    !rx_detect_reset_override_r |=> rxDetectReset == $past(rxDetectAutoReset))
    else $error("automatic rx-detect reset not passed through");
  a_pd_reg: assert property (
    wrOvr && wrData[0] ##1 !wrOvr |=>
    channel_power_down == $past(channelPowerDownReg))
    else $error("register power-down not applied");
  a_pd_pin: assert property (
    !power_down_pin_override_r |=>
    channel_power_down == {rdsc_pkg::CHANS{$past(powerDownPin)}})
    else $error("power-down pin ignored");
  a_en_reset: assert property (
    $rose(rst_n) |-> rdSlv == rdsc_pkg::RST_SLV && !registerEnable)
    else $error("slave control wrong after reset");
  a_gate_off: assert property (
    wrSlv && !wrData[3] ##1 !wrSlv |=> output_swing == $past(pinSwing)
    && equalizer_boost == $past(pinBoost))
    else $error("register settings applied while disabled");
  a_regs_default: assert property (
    s_rst_req |=> registerFileReset ##1 s_defaults)
    else $error("register reset did not restore defaults");
  a_mst_pulse: assert property (
    s_mst_req |=> masterSmReset ##1 !masterSmReset)
    else $error("master reset not a single pulse");
  a_self_clear: assert property (
    s_rst_req or s_mst_req |=> ##1 rdDrst == rdsc_pkg::RST_DRST [*2])
    else $error("reset bits do not read back cleared");
endmodule : rdsc_ctrl_regs
`default_nettype wire

/* testbench/rdsc_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module rdsc_host_model (
  input  wire logic clock,
  input  wire logic sda,
  output logic      scl,
  output logic      sdaDrv
);
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end
  // slave needs each scl level seen for at least 2 clocks
  task automatic hold();
    repeat (4) @(negedge clock);
  endtask : hold
  task automatic start();
    sdaDrv = 1'b1;
    hold();
    scl = 1'b1;
    hold();
    sdaDrv = 1'b0;
    hold();
    scl = 1'b0;
    hold();
  endtask : start
  task automatic stop();
    sdaDrv = 1'b0;
    hold();
    scl = 1'b1;
    hold();
    sdaDrv = 1'b1;
    hold();
  endtask : stop
  // data only changes while scl is low; b = 1 releases the line
  task automatic bitIo(input logic b, output logic s);
    sdaDrv = b;
    hold();
    scl = 1'b1;
    hold();
    s = sda;
    scl = 1'b0;
    hold();
  endtask : bitIo
  // msb-first byte, ack sampled in ninth bit
  task automatic sendByte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitIo(d[i], s);
    end
    bitIo(1'b1, ack);
  endtask : sendByte
  task automatic recvByte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitIo(1'b1, d[i]);
    end
    bitIo(nack, s);
  endtask : recvByte
endmodule : rdsc_host_model
`default_nettype wire

/* testbench/test_redriver_smbus_control_regs.sv */
`timescale 1ns/10ps
`default_nettype none
module test_redriver_smbus_control_regs;
  logic       clock, rst_n, scl, hostSda, sda, sdaOut, sdaOen_n;
  logic       powerDownPin, rxDetectAutoReset, rxDetectReset;
  logic       registerEnable, registerFileReset, masterSmReset;
  logic [7:0] chPdReg, chPd, rd;
  logic [2:0] swing, deemph, boost, pinSw;
  int         numErrors, nCompared, nRf, nMst;
  // open drain with pull-up: low if either party pulls
  assign sda = hostSda & (sdaOen_n | sdaOut);
  rdsc_host_model u_host (.clock(clock), .sda(sda), .scl(scl),
    .sdaDrv(hostSda));
  rdsc_ctrl_regs u_dut (.clock(clock), .rst_n(rst_n), .scl(scl),
    .sdaIn(sda), .sdaOut(sdaOut), .sdaOen_n(sdaOen_n),
    .powerDownPin(powerDownPin), .channelPowerDownReg(chPdReg),
    .channel_power_down(chPd), .rxDetectAutoReset(rxDetectAutoReset),
    .rxDetectReset(rxDetectReset), .pinSwing(pinSw), .pinDeemphasis(3'h2),
    .pinBoost(3'h3), .regSwing(3'h5), .regDeemphasis(3'h6),
    .regBoost(3'h7), .output_swing(swing), .output_deemphasis(deemph),
    .equalizer_boost(boost), .registerEnable(registerEnable),
    .registerFileReset(registerFileReset), .masterSmReset(masterSmReset));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // count on the falling edge, where the pulse outputs have settled
  always @(negedge clock) begin
    if (registerFileReset === 1'b1) nRf++;
    if (masterSmReset === 1'b1) nMst++;
  end
  task automatic closeOut();
    $display("checks %0d, mismatches %0d", nCompared, numErrors);
    if (numErrors == 0 && nCompared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : closeOut
  task automatic chk(input string what, input logic [15:0] exp, got);
    nCompared++;
    if (got !== exp) begin
      numErrors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic regWrite(input logic [7:0] ofs, dat);
    logic a0, a1, a2;
    u_host.start();
    u_host.sendByte({rdsc_pkg::DEV_ADDR, 1'b0}, a0);
    u_host.sendByte(ofs, a1);
    u_host.sendByte(dat, a2);
    u_host.stop();
    chk("write acks", 16'h0000, {13'h0000, a0, a1, a2});
  endtask : regWrite
  task automatic rdChk(input logic [7:0] ofs, exp);
    logic a0, a1, a2;
    u_host.start();
    u_host.sendByte({rdsc_pkg::DEV_ADDR, 1'b0}, a0);
    u_host.sendByte(ofs, a1);
    u_host.start();
    u_host.sendByte({rdsc_pkg::DEV_ADDR, 1'b1}, a2);
    u_host.recvByte(1'b1, rd);
    u_host.stop();
    chk("read acks", 16'h0000, {13'h0000, a0, a1, a2});
    chk("read data", {8'h00, exp}, {8'h00, rd});
  endtask : rdChk
  task automatic chkSet(input logic [8:0] exp);
    chk("settings", {7'h00, exp}, {7'h00, swing, deemph, boost});
  endtask : chkSet
  task automatic done(input string name);
    $display("test %s done, mismatches %0d", name, numErrors);
  endtask : done
  initial begin
    repeat (100000) @(posedge clock);
    numErrors++;
    closeOut();
  end
  initial begin
    logic        ack;
    logic [7:0]  rstTab [6];
    rstTab = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h01};
    rst_n = 1'b0;
    powerDownPin = 1'b1;
    chPdReg = 8'hA5;
    pinSw = 3'h1;
    rxDetectAutoReset = 1'b1;
    repeat (12) @(negedge clock);
    rst_n = 1'b1;
    repeat (4) @(negedge clock);
    for (int i = 0; i < 6; i++) rdChk(8'(i + 2), rstTab[i]);
    rdChk(8'h08, 8'h00);
    done("reset values");
    u_host.start();
    u_host.sendByte({7'h59, 1'b0}, ack);
    u_host.stop();
    chk("foreign address ack", 16'h0001, {15'h0000, ack});
    done("foreign address");
    chk("pin power down", 16'h00FF, {8'h00, chPd});
    // both pin sources low, so a stuck pass-through shows up
    powerDownPin = 1'b0;
    rxDetectAutoReset = 1'b0;
    repeat (2) @(negedge clock);
    chk("pin power up", 16'h0000, {8'h00, chPd});
    chk("auto detect low", 16'h0000, {15'h0000, rxDetectReset});
    powerDownPin = 1'b1;
    rxDetectAutoReset = 1'b1;
    regWrite(8'h02, 8'h01);
    chk("register power down", 16'h00A5, {8'h00, chPd});
    chk("auto detect reset", 16'h0001, {15'h0000, rxDetectReset});
    regWrite(8'h02, 8'h81);
    chk("forced detect clear", 16'h0000, {15'h0000, rxDetectReset});
    regWrite(8'h02, 8'hC1);
    chk("forced detect set", 16'h0001, {15'h0000, rxDetectReset});
    // overrides on: pin and automatic reset must both be ignored
    powerDownPin = 1'b0;
    rxDetectAutoReset = 1'b0;
    repeat (2) @(negedge clock);
    chk("pin ignored", 16'h00A5, {8'h00, chPd});
    chk("auto ignored", 16'h0001, {15'h0000, rxDetectReset});
    powerDownPin = 1'b1;
    rxDetectAutoReset = 1'b1;
    rdChk(8'h02, 8'hC1);
    done("override");
    chkSet({3'h1, 3'h2, 3'h3});
    // enable first, as the host must before relying on register settings
    regWrite(8'h06, 8'hFF);
    chk("register enable", 16'h0001, {15'h0000, registerEnable});
    chkSet({3'h5, 3'h6, 3'h7});
    rdChk(8'h06, 8'h18);
    // pin change while enabled must not reach the outputs
    pinSw = 3'h4;
    repeat (2) @(negedge clock);
    chkSet({3'h5, 3'h6, 3'h7});
    regWrite(8'h06, 8'h10);
    chk("register disable", 16'h0000, {15'h0000, registerEnable});
    chkSet({3'h4, 3'h2, 3'h3});
    pinSw = 3'h1;
    regWrite(8'h06, 8'h18);
    regWrite(8'h03, 8'hFF);
    rdChk(8'h03, 8'h00);
    done("slave control");
    // low field kept at 00001 on every write
    regWrite(8'h07, 8'h21);
    chk("master reset pulses", 16'h0001, nMst[15:0]);
    rdChk(8'h07, rdsc_pkg::RST_DRST);
    rdChk(8'h06, 8'h18);
    regWrite(8'h07, 8'h41);
    chk("file reset pulses", 16'h0001, nRf[15:0]);
    rdChk(8'h02, rdsc_pkg::RST_OVR);
    rdChk(8'h06, rdsc_pkg::RST_SLV);
    rdChk(8'h07, rdsc_pkg::RST_DRST);
    chkSet({3'h1, 3'h2, 3'h3});
    chk("pin power down again", 16'h00FF, {8'h00, chPd});
    done("self clearing resets");
    closeOut();
  end
endmodule : test_redriver_smbus_control_regs
`default_nettype wire
